// ===== bus_host_model.sv
// Host controller of the two-wire bus: drives SCL, pulls SDA low, samples it.
// Assumes a pull-up on SDA; changes lines on the falling edge of clk_in.
`timescale 1ns/1ps

module bus_host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output      logic scl_out,
  output      logic sda_pull_out
);
  // ****************************************
  // Bit and byte tasks
  // ****************************************
  initial begin
    scl_out      = 1'b1;
    sda_pull_out = 1'b0;
  end

  // Four cycles keep SDA moves clear of SCL edges
  task automatic gap;
    repeat (4) @(negedge clk_in);
  endtask

  task automatic start;
    sda_pull_out = 1'b0;
    gap();
    scl_out = 1'b1;
    gap();
    sda_pull_out = 1'b1;
    gap();
    scl_out = 1'b0;
    gap();
  endtask

  task automatic stop;
    sda_pull_out = 1'b1;
    gap();
    scl_out = 1'b1;
    gap();
    sda_pull_out = 1'b0;
    gap();
    gap();
  endtask

  task automatic clk_bit(input logic b, output logic r);
    sda_pull_out = ~b;
    gap();
    scl_out = 1'b1;
    repeat (2) @(negedge clk_in);
    r = sda_in;
    repeat (2) @(negedge clk_in);
    scl_out = 1'b0;
    gap();
  endtask

  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rx(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(~more, r);
  endtask
endmodule

// ===== eeprom_engine_asserts.sv
// Checker of the EEPROM transfer engine: bus drive timing and program cycle.
// Assumes a bind to eeprom_transfer_engine, SCL and SDA sampled on ref_clk_in.
`timescale 1ns/1ps

module eeprom_engine_asserts #(
  parameter int PROG_CYCLES = 400
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic chip_select_strap_high_in,
  input wire logic chip_select_strap_mid_in,
  input wire logic chip_select_strap_low_in,
  input wire logic program_busy_out
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic        scl_p_r;
  logic        sda_p_r;
  logic        frame_r;
  logic [3:0]  since_stop_r;
  logic [31:0] busy_cnt_r;
  wire         stop_now  = scl_in & scl_p_r & sda_in & ~sda_p_r;
  wire         start_now = scl_in & scl_p_r & ~sda_in & sda_p_r;

  // Age since stop saturates, so a late rise of busy still reads as late
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_p_r      <= 1'b1;
      sda_p_r      <= 1'b1;
      frame_r      <= 1'b0;
      since_stop_r <= 4'hF;
      busy_cnt_r   <= 32'h0;
    end else begin
      scl_p_r      <= scl_in;
      sda_p_r      <= sda_in;
      frame_r      <= start_now | (frame_r & ~stop_now);
      since_stop_r <= stop_now ? 4'h0 : (since_stop_r == 4'hF ? 4'hF : since_stop_r + 4'h1);
      busy_cnt_r   <= program_busy_out ? busy_cnt_r + 32'h1 : 32'h0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_drive_only_low: assert property (!sda_oe_n_out |-> sda_out == 1'b0)
    else $error("device drives SDA high");
  // The drive register moves one edge after the SCL fall is seen, so look at this and the last
  a_oe_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in && !$past(scl_in))
    else $error("SDA drive changed while SCL high");
  a_drive_in_frame: assert property (!sda_oe_n_out |-> frame_r)
    else $error("SDA driven outside a frame");
  a_busy_silent: assert property (program_busy_out |-> sda_oe_n_out)
    else $error("SDA driven during program cycle");
  a_busy_from_stop: assert property ($rose(program_busy_out) |-> since_stop_r <= 4'h3)
    else $error("program cycle began without a stop");
  a_busy_holds: assert property ($rose(program_busy_out) |=> program_busy_out [*8])
    else $error("program cycle cut short");
  a_busy_bound: assert property (program_busy_out |-> busy_cnt_r < PROG_CYCLES)
    else $error("program cycle too long");
  a_busy_length: assert property ($fell(program_busy_out) |-> busy_cnt_r == PROG_CYCLES)
    else $error("program cycle length wrong");

  c_ack_driven: cover property ($fell(sda_oe_n_out));
  c_prog_start: cover property ($rose(program_busy_out));
  c_prog_end: cover property ($fell(program_busy_out));
endmodule

bind eeprom_transfer_engine eeprom_engine_asserts #(.PROG_CYCLES(PROG_CYCLES))
  u_eeprom_engine_asserts (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .chip_select_strap_high_in(chip_select_strap_high_in),
  .chip_select_strap_mid_in(chip_select_strap_mid_in),
  .chip_select_strap_low_in(chip_select_strap_low_in),
  .program_busy_out(program_busy_out));

// ===== eeprom_engine_map.svh
// Constants of the serial EEPROM transfer engine: codes, bit slots, timing.
// Assumes inclusion by bare name from the design files.
`ifndef EEPROM_ENGINE_MAP_SVH
`define EEPROM_ENGINE_MAP_SVH

// ****************************************
// Select byte layout
// ****************************************
`define SEL_FIXED_CODE     4'hA
`define SEL_DIR_READ       1'b1

// ****************************************
// Bit slots within one byte frame
// ****************************************
`define SLOT_FIRST         4'h0
`define SLOT_ACK           4'h8
`define SLOT_DONE          4'h9

// ****************************************
// Page and array geometry
// ****************************************
`define PAGE_BITS_SMALL    3
`define PAGE_BITS_LARGE    4
`define WORD_ADDR_BITS     8
`define DENSITY_DEFAULT    3

// ****************************************
// Timing and page buffer depth
// ****************************************
`define CLK_FREQ_HZ        40000000
`define PROG_CYCLE_TIME_MS 10
`define MS_PER_S           1000
`define FIFO_DEPTH_WORDS   32

`endif

// ===== eeprom_engine_pkg.sv
// Types shared by the serial EEPROM transfer engine.
// Assumes nothing of its surroundings.
package eeprom_engine_pkg;

  // ****************************************
  // Transfer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SELECT,
    ST_WORD_ADDR,
    ST_WRITE_DATA,
    ST_READ_DATA,
    ST_PROGRAM
  } xfer_state_type;

endpackage

// ===== eeprom_transfer_engine.sv
// Target-side two-wire transfer engine of a small serial EEPROM with its array.
// Assumes serial clock and data inputs synchronous to ref_clk_in, host-driven clock.
`timescale 1ns/1ps

`include "eeprom_engine_map.svh"

module eeprom_transfer_engine
  import eeprom_engine_pkg::*;
#(
  parameter int DENSITY     = `DENSITY_DEFAULT,
  parameter int PROG_CYCLES = (`PROG_CYCLE_TIME_MS * `CLK_FREQ_HZ) / `MS_PER_S,
  parameter int FIFO_DEPTH  = `FIFO_DEPTH_WORDS
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output      logic sda_out,
  output      logic sda_oe_n_out,
  input  wire logic chip_select_strap_high_in,
  input  wire logic chip_select_strap_mid_in,
  input  wire logic chip_select_strap_low_in,
  output      logic program_busy_out
);

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W    = `WORD_ADDR_BITS + DENSITY;
  localparam int PAGE_W    = (DENSITY == 0) ? `PAGE_BITS_SMALL : `PAGE_BITS_LARGE;
  localparam int ENTRY_W   = ADDR_W + `WORD_ADDR_BITS;
  localparam int TIMER_W   = $clog2(PROG_CYCLES + 1);
  localparam logic [ADDR_W-1:0] PAGE_MASK = ADDR_W'((1 << PAGE_W) - 1);
  localparam logic [2:0]        CMP_MASK  = 3'(3'h7 << DENSITY);
  localparam logic [TIMER_W-1:0] TIMER_END = TIMER_W'(PROG_CYCLES - 1);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ****************************************
  // State
  // ****************************************
  xfer_state_type     state_r;
  xfer_state_type     state_nxt;
  logic [3:0]         bit_cnt_r;
  logic [3:0]         bit_cnt_nxt;
  logic [7:0]         rx_r;
  logic [7:0]         rx_nxt;
  logic [7:0]         tx_r;
  logic [7:0]         tx_nxt;
  logic               oe_n_r;
  logic               oe_n_nxt;
  logic [2:0]         sel_page_r;
  logic [2:0]         sel_page_nxt;
  logic               dir_read_r;
  logic               dir_read_nxt;
  logic               acked_r;
  logic               acked_nxt;
  logic               host_ack_r;
  logic               host_ack_nxt;
  logic [ADDR_W-1:0]  addr_cnt_r;
  logic [ADDR_W-1:0]  addr_cnt_nxt;
  logic [TIMER_W-1:0] timer_r;
  logic [TIMER_W-1:0] timer_nxt;
  logic               scl_prev_r;
  logic               sda_prev_r;
  logic [7:0]         array_r [1 << ADDR_W];

  // ****************************************
  // Bus events and decode
  // ****************************************
  logic               scl_rise;
  logic               scl_fall;
  logic               start_det;
  logic               stop_det;
  logic [2:0]         strap_bits;
  logic               sel_match;
  logic [ADDR_W-1:0]  loaded_addr;
  logic [ADDR_W-1:0]  page_next;
  logic [ADDR_W-1:0]  array_next;
  logic [7:0]         array_rdata;
  logic               push_valid;
  logic               push_ready;
  logic               drain_valid;
  logic               drain_ready;
  logic [ENTRY_W-1:0] drain_data;
  logic               timer_done;

  assign scl_rise    = scl_in && !scl_prev_r;
  assign scl_fall    = !scl_in && scl_prev_r;
  assign start_det   = scl_in && scl_prev_r && sda_prev_r && !sda_in;
  assign stop_det    = scl_in && scl_prev_r && !sda_prev_r && sda_in;
  assign strap_bits  = {chip_select_strap_high_in, chip_select_strap_mid_in,
                        chip_select_strap_low_in};
  assign sel_match   = (rx_r[7:4] == `SEL_FIXED_CODE) &&
                       (((rx_r[3:1] ^ strap_bits) & CMP_MASK) == 3'h0);
  assign loaded_addr = ADDR_W'({sel_page_r, rx_r});
  assign page_next   = (addr_cnt_r & ~PAGE_MASK) | ((addr_cnt_r + 1'b1) & PAGE_MASK);
  assign array_next  = addr_cnt_r + 1'b1;
  assign array_rdata = array_r[addr_cnt_r];
  assign drain_ready = (state_r == ST_PROGRAM);
  assign timer_done  = (timer_r == TIMER_END);
  assign push_valid  = (state_r == ST_WRITE_DATA) && scl_fall && (bit_cnt_r == `SLOT_ACK);

  // ****************************************
  // Transfer sequencing
  // ****************************************
  always_comb begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    rx_nxt       = rx_r;
    tx_nxt       = tx_r;
    oe_n_nxt     = oe_n_r;
    sel_page_nxt = sel_page_r;
    dir_read_nxt = dir_read_r;
    acked_nxt    = acked_r;
    host_ack_nxt = host_ack_r;
    addr_cnt_nxt = addr_cnt_r;
    timer_nxt    = timer_r;
    if (state_r == ST_PROGRAM) begin
      // Bus is deaf here, so polling selects go unanswered
      oe_n_nxt = 1'b1;
      if (!timer_done) begin
        timer_nxt = timer_r + 1'b1;
      end else if (!drain_valid) begin
        state_nxt = ST_IDLE;
      end
    end else if (stop_det) begin
      oe_n_nxt  = 1'b1;
      timer_nxt = '0;
      // Only whole data bytes sit in the buffer, so an empty one means no program
      if (state_r == ST_WRITE_DATA && drain_valid) begin
        state_nxt = ST_PROGRAM;
      end else begin
        state_nxt = ST_IDLE;
      end
    end else if (start_det) begin
      state_nxt   = ST_SELECT;
      bit_cnt_nxt = `SLOT_FIRST;
      oe_n_nxt    = 1'b1;
    end else if (state_r != ST_IDLE && scl_rise) begin
      if (bit_cnt_r < `SLOT_ACK) begin
        rx_nxt = {rx_r[6:0], sda_in};
        tx_nxt = {tx_r[6:0], 1'b1};
      end else begin
        host_ack_nxt = !sda_in;
      end
      if (bit_cnt_r != `SLOT_DONE) begin
        bit_cnt_nxt = bit_cnt_r + 1'b1;
      end
    end else if (state_r != ST_IDLE && scl_fall) begin
      if (bit_cnt_r == `SLOT_ACK) begin
        acked_nxt = 1'b0;
        oe_n_nxt  = 1'b1;
        case (state_r)
          ST_SELECT: begin
            acked_nxt    = sel_match;
            dir_read_nxt = (rx_r[0] == `SEL_DIR_READ);
            sel_page_nxt = rx_r[3:1];
          end
          ST_WORD_ADDR: begin
            acked_nxt    = 1'b1;
            addr_cnt_nxt = loaded_addr;
          end
          ST_WRITE_DATA: begin
            // A full buffer refuses the byte rather than lose it
            acked_nxt = push_ready;
            if (push_ready) begin
              addr_cnt_nxt = page_next;
            end
          end
          default: begin
            acked_nxt = 1'b0;
          end
        endcase
        oe_n_nxt = !acked_nxt && (state_r != ST_READ_DATA) ? 1'b1 : (state_r == ST_READ_DATA);
      end else if (bit_cnt_r == `SLOT_DONE) begin
        bit_cnt_nxt = `SLOT_FIRST;
        oe_n_nxt    = 1'b1;
        case (state_r)
          ST_SELECT: begin
            if (!acked_r) begin
              state_nxt = ST_IDLE;
            end else if (dir_read_r) begin
              state_nxt    = ST_READ_DATA;
              tx_nxt       = array_rdata;
              oe_n_nxt     = array_rdata[7];
              addr_cnt_nxt = array_next;
            end else begin
              state_nxt = ST_WORD_ADDR;
            end
          end
          ST_WORD_ADDR: begin
            state_nxt = ST_WRITE_DATA;
          end
          ST_WRITE_DATA: begin
            state_nxt = acked_r ? ST_WRITE_DATA : ST_IDLE;
          end
          ST_READ_DATA: begin
            if (host_ack_r) begin
              tx_nxt       = array_rdata;
              oe_n_nxt     = array_rdata[7];
              addr_cnt_nxt = array_next;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
          default: begin
            state_nxt = ST_IDLE;
          end
        endcase
      end else if (state_r == ST_READ_DATA) begin
        oe_n_nxt = tx_r[7];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r          <= ST_IDLE;
      bit_cnt_r        <= `SLOT_FIRST;
      rx_r             <= 8'h00;
      tx_r             <= 8'hFF;
      oe_n_r           <= 1'b1;
      sel_page_r       <= 3'h0;
      dir_read_r       <= 1'b0;
      acked_r          <= 1'b0;
      host_ack_r       <= 1'b0;
      addr_cnt_r       <= '0;
      timer_r          <= '0;
      scl_prev_r       <= 1'b1;
      sda_prev_r       <= 1'b1;
      sda_out          <= 1'b0;
      sda_oe_n_out     <= 1'b1;
      program_busy_out <= 1'b0;
    end else begin
      state_r          <= state_nxt;
      bit_cnt_r        <= bit_cnt_nxt;
      rx_r             <= rx_nxt;
      tx_r             <= tx_nxt;
      oe_n_r           <= oe_n_nxt;
      sel_page_r       <= sel_page_nxt;
      dir_read_r       <= dir_read_nxt;
      acked_r          <= acked_nxt;
      host_ack_r       <= host_ack_nxt;
      addr_cnt_r       <= addr_cnt_nxt;
      timer_r          <= timer_nxt;
      scl_prev_r       <= scl_in;
      sda_prev_r       <= sda_in;
      sda_out          <= 1'b0;
      sda_oe_n_out     <= oe_n_nxt;
      program_busy_out <= (state_nxt == ST_PROGRAM);
    end
  end

  // ****************************************
  // Page buffer and array programming
  // ****************************************
  word_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_page_fifo (
    .clk_in        (ref_clk_in),
    .rst_n_in      (rst_sync_r),
    .in_valid_in   (push_valid && push_ready),
    .in_ready_out  (push_ready),
    .in_data_in    ({addr_cnt_r, rx_r}),
    .out_valid_out (drain_valid),
    .out_ready_in  (drain_ready),
    .out_data_out  (drain_data)
  );

  // Entries drain in arrival order, so a wrapped page keeps the later byte
  always_ff @(posedge ref_clk_in) begin
    if (drain_valid && drain_ready) begin
      array_r[drain_data[ENTRY_W-1:`WORD_ADDR_BITS]] <= drain_data[7:0];
    end
  end

endmodule

// ===== tb_top.sv
// Self-checking bench of the EEPROM transfer engine: writes, polls and reads.
// Assumes the host model and checker files compiled before it.
`timescale 1ns/1ps

module tb_top;
  // Short program cycle, still longer than one polling select byte
  localparam int PROG = 400;
  logic        ref_clk_in, rst_n_in, strap_high, strap_mid, strap_low;
  logic        sda_out, sda_oe_n_out, program_busy_out, scl, host_pull, ack;
  wire         sda_w = ~host_pull & (sda_oe_n_out | sda_out);
  logic [7:0]  mem [2048];
  logic [10:0] cnt, a;
  int          seed = 32'h508BB452;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  eeprom_transfer_engine #(.PROG_CYCLES(PROG)) u_eeprom_transfer_engine (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .chip_select_strap_high_in(strap_high), .chip_select_strap_mid_in(strap_mid),
    .chip_select_strap_low_in(strap_low), .program_busy_out(program_busy_out));
  bus_host_model u_bus_host_model (
    .clk_in(ref_clk_in), .sda_in(sda_w), .scl_out(scl), .sda_pull_out(host_pull));

  // ****************************************
  // Expectation helpers
  // ****************************************
  function automatic logic [7:0] sel(input logic [10:0] ad, input logic rd);
    return {4'hA, ad[10:8], rd};
  endfunction
  function automatic logic [10:0] page_next(input logic [10:0] ad);
    return {ad[10:4], ad[3:0] + 4'h1};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Transfers
  // ****************************************
  task automatic write_page(input logic [10:0] ad, input int n);
    logic [7:0] d;
    int         polls;
    u_bus_host_model.start();
    u_bus_host_model.tx(sel(ad, 1'b0), ack);
    chk({7'h0, ack}, 8'h01);
    u_bus_host_model.tx(ad[7:0], ack);
    chk({7'h0, ack}, 8'h01);
    cnt = ad;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      u_bus_host_model.tx(d, ack);
      chk({7'h0, ack}, 8'h01);
      mem[cnt] = d;
      cnt = page_next(cnt);
    end
    u_bus_host_model.stop();
    chk({7'h0, program_busy_out}, 8'h01);
    polls = 0;
    ack = 1'b0;
    while (!ack && polls < 12) begin
      u_bus_host_model.start();
      u_bus_host_model.tx(sel(cnt, 1'b0), ack);
      u_bus_host_model.stop();
      if (polls == 0) chk({7'h0, ack}, 8'h00);
      polls++;
    end
    chk({7'h0, ack}, 8'h01);
  endtask

  task automatic read_seq(input logic [10:0] ad, input logic rnd, input int n);
    logic [7:0] d;
    if (rnd) begin
      u_bus_host_model.start();
      u_bus_host_model.tx(sel(ad, 1'b0), ack);
      chk({7'h0, ack}, 8'h01);
      u_bus_host_model.tx(ad[7:0], ack);
      chk({7'h0, ack}, 8'h01);
      cnt = ad;
    end
    u_bus_host_model.start();
    u_bus_host_model.tx(sel(ad, 1'b1), ack);
    chk({7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      u_bus_host_model.rx(i < n - 1, d);
      chk(d, mem[cnt]);
      cnt = cnt + 11'h1;
    end
    u_bus_host_model.stop();
  endtask

  // ****************************************
  // Clock, sequence and watchdog
  // ****************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    rst_n_in = 1'b0;
    {strap_high, strap_mid, strap_low} = 3'($random(seed));
    repeat (12) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    u_bus_host_model.start();
    u_bus_host_model.tx(8'hB0, ack);
    chk({7'h0, ack}, 8'h00);
    u_bus_host_model.stop();
    write_page(11'h7F0, 16);
    write_page(11'h000, 16);
    a = 11'($random(seed));
    write_page(a, 18);
    read_seq({a[10:4], 4'h0}, 1'b1, 16);
    read_seq(11'h7FE, 1'b1, 4);
    read_seq(11'h000, 1'b0, 1);
    u_bus_host_model.start();
    u_bus_host_model.tx(sel(11'h7F5, 1'b0), ack);
    u_bus_host_model.tx(8'hF5, ack);
    u_bus_host_model.stop();
    repeat (10) @(negedge ref_clk_in);
    chk({7'h0, program_busy_out}, 8'h00);
    cnt = 11'h7F5;
    read_seq(11'h7F5, 1'b0, 1);
    complete_run();
  end

  initial begin
    repeat (90000) @(posedge ref_clk_in);
    n_mismatch++;
    complete_run();
  end
endmodule

// ===== word_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronised active-low reset.
`timescale 1ns/1ps

module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output      logic             in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output      logic             out_valid_out,
  input  wire logic             out_ready_in,
  output      logic [WIDTH-1:0] out_data_out
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [PW:0]      wr_ptr_r;
  logic [PW:0]      rd_ptr_r;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // ****************************************
  // Pointer compare, extra bit tells full from empty
  // ****************************************
  assign full          = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
  assign empty         = (wr_ptr_r == rd_ptr_r);
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = store_r[rd_ptr_r[PW-1:0]];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // Storage carries no reset; only written words are ever read
  always_ff @(posedge clk_in) begin
    if (push) begin
      store_r[wr_ptr_r[PW-1:0]] <= in_data_in;
    end
  end

endmodule
